// ### logic/hbpm_pkg.sv
// Package for the host bus pin mapping block: modes, widths, structs.
// Assumes a single 200 MHz clock domain; all users import hbpm_pkg::*.
`default_nettype none
package hbpm_pkg;

  // ==========================================================
  // Widths and timing
  localparam int HBPM_ADDR_W = 16;
  localparam int HBPM_BASE_LSB = 4;
  localparam int HBPM_BASE_W = HBPM_ADDR_W - HBPM_BASE_LSB;
  localparam int HBPM_CLK_PERIOD_PS = 5000;
  localparam int HBPM_WAIT_NS = 20;
  localparam int HBPM_WAIT_CYC = (HBPM_WAIT_NS * 1000 + HBPM_CLK_PERIOD_PS - 1)
                                 / HBPM_CLK_PERIOD_PS;
  localparam int HBPM_CNT_W = 8;

  // ==========================================================
  // Reset values
  localparam logic [HBPM_ADDR_W-1:0] HBPM_ADDR_RST = 16'h0000;
  localparam logic [HBPM_CNT_W-1:0] HBPM_CNT_ZERO = 8'h00;

  // ==========================================================
  // Host bus mode
  typedef enum logic {
    HBPM_MODE_ISA,
    HBPM_MODE_MPU
  } hbpm_mode_e;

  // Access sequencer states
  typedef enum logic [1:0] {
    HBPM_IDLE,
    HBPM_WAIT,
    HBPM_DONE
  } hbpm_state_e;

  // Host side pin group (after synchronisers)
  typedef struct packed {
    logic addr_strobe;
    logic byte_high_n;
    logic data_strobe_n;
    logic [HBPM_ADDR_W-1:0] addr;
  } hbpm_host_s;

endpackage
`default_nettype wire

// ### logic/hbpm_sync.sv
// Two-flop synchroniser for host pins arriving from outside the clock.
// Assumes the first stage feeds only the second stage.
`timescale 1ns/1ps
`default_nettype none
module hbpm_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } hbpm_sync_s;

  hbpm_sync_s st_reg;
  hbpm_sync_s st_next;

  // ==========================================================
  // Next state
  always_comb begin
    st_next.meta = din;
    st_next.stable = st_reg.meta;
  end

  // Registers
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign dout = st_reg.stable;
endmodule
`default_nettype wire

// ### logic/hbpm_core.sv
// Host bus pin mapping: ISA-style and asynchronous processor bus modes.
// Assumes host pins are asynchronous; mode strap and reset pin are pins.
// Contract
// - ISA mode latches address and byte-high enable as the strobe falls.
// - ISA mode holds channel ready low while wait states are needed.
// - ISA mode asserts 16-bit chip select when A[15:4] equals the base.
// - Processor mode: acknowledge marks completion; address latches at cycle start.
`timescale 1ns/1ps
`default_nettype none
module hbpm_core
  import hbpm_pkg::*;
#(
  parameter int WAIT_CYC = hbpm_pkg::HBPM_WAIT_CYC
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire hbpm_pkg::hbpm_mode_e bus_mode,
  input wire logic chip_reset_pin,
  input wire hbpm_pkg::hbpm_host_s host_pins,
  input wire logic [hbpm_pkg::HBPM_BASE_W-1:0] base_addr,
  input wire logic irq_event,
  input wire logic access_ready,
  output logic chan_ready,
  output logic io_cs16_n,
  output logic isa_interrupt_line_zero,
  output logic mpu_irq,
  output logic xfer_ack_n,
  output logic [hbpm_pkg::HBPM_ADDR_W-1:0] latched_addr,
  output logic latched_byte_high_n,
  output logic access_req,
  output logic chip_rst
);
  import hbpm_pkg::*;

  localparam int PIN_W = $bits(hbpm_host_s) + 1;

  typedef struct packed {
    hbpm_state_e state;
    logic strobe_d;
    logic ds_d;
    logic [HBPM_ADDR_W-1:0] addr;
    logic bhe_n;
    logic [HBPM_CNT_W-1:0] cnt;
    logic ready;
    logic cs16_n;
    logic ack_n;
    logic irq;
    logic req;
  } hbpm_core_s;

  hbpm_core_s st_reg;
  hbpm_core_s st_next;
  hbpm_host_s hp;
  logic rst_pin_s;
  logic [PIN_W-1:0] sync_out;
  logic strobe_fall;
  logic cycle_start;
  logic cycle_end;
  logic isa_mode;

  // ==========================================================
  // Pin synchronisers
  hbpm_sync #(.WIDTH(PIN_W)) hbpm_sync_i (
    .clock(clock),
    .sys_rst(sys_rst),
    .din({chip_reset_pin, host_pins}),
    .dout(sync_out)
  );
  assign hp = hbpm_host_s'(sync_out[PIN_W-2:0]);
  assign rst_pin_s = sync_out[PIN_W-1];
  assign isa_mode = (bus_mode == HBPM_MODE_ISA);

  // Chip reset polarity by mode
  assign chip_rst = isa_mode ? rst_pin_s : ~rst_pin_s;

  // Strobe edges
  assign strobe_fall = st_reg.strobe_d & ~hp.addr_strobe;
  // Processor cycles start on a falling data strobe: the synchroniser
  // leaves reset at zero, so a level test would start a false cycle
  assign cycle_start = isa_mode ? strobe_fall :
    (st_reg.ds_d & ~hp.data_strobe_n);
  assign cycle_end = isa_mode ? hp.addr_strobe : hp.data_strobe_n;

  // ==========================================================
  // Next state
  always_comb begin
    st_next = st_reg;
    st_next.strobe_d = hp.addr_strobe;
    st_next.ds_d = hp.data_strobe_n;
    st_next.irq = irq_event;
    st_next.req = 1'b0;
    // Address capture on falling strobe edge in ISA mode; processor mode tracks the address while idle
    if (isa_mode && strobe_fall) begin
      st_next.addr = hp.addr;
      st_next.bhe_n = hp.byte_high_n;
    end else if (!isa_mode && st_reg.state == HBPM_IDLE) begin
      st_next.addr = hp.addr;
      st_next.bhe_n = 1'b1;
    end
    // Chip select decode on latched address
    st_next.cs16_n = ~(isa_mode &&
      st_next.addr[HBPM_ADDR_W-1:HBPM_BASE_LSB] == base_addr);
    case (st_reg.state)
      HBPM_IDLE: begin
        st_next.ready = 1'b1;
        st_next.ack_n = 1'b1;
        if (cycle_start) begin
          st_next.state = HBPM_WAIT;
          st_next.cnt = HBPM_CNT_ZERO;
          st_next.req = 1'b1;
          st_next.ready = ~isa_mode ? 1'b1 : 1'b0;
        end
      end
      HBPM_WAIT: begin
        st_next.cnt = st_reg.cnt + 8'h01;
        if (access_ready && st_reg.cnt >= HBPM_CNT_W'(WAIT_CYC - 1)) begin
          st_next.state = HBPM_DONE;
          st_next.ready = 1'b1;
          st_next.ack_n = isa_mode;
        end
      end
      HBPM_DONE: begin
        if (cycle_end) begin
          st_next.state = HBPM_IDLE;
          st_next.ack_n = 1'b1;
        end
      end
      default: st_next.state = HBPM_IDLE;
    endcase
  end

  // Registers
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      // Strobe history resets low like the synchroniser: no false edge
      st_reg <= '{state: HBPM_IDLE, strobe_d: 1'b0, ds_d: 1'b0,
                  addr: HBPM_ADDR_RST, bhe_n: 1'b1, cnt: HBPM_CNT_ZERO,
                  ready: 1'b1, cs16_n: 1'b1, ack_n: 1'b1, irq: 1'b0,
                  req: 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

  // ==========================================================
  // Outputs
  assign chan_ready = st_reg.ready;
  assign io_cs16_n = st_reg.cs16_n;
  assign xfer_ack_n = st_reg.ack_n;
  assign latched_addr = st_reg.addr;
  assign latched_byte_high_n = st_reg.bhe_n;
  assign access_req = st_reg.req;
  // One unencoded line per mode; system routes processor line to a level
  assign isa_interrupt_line_zero = isa_mode & st_reg.irq;
  assign mpu_irq = ~isa_mode & st_reg.irq;

  // ==========================================================
  // Checks
  a_addr_capture: assert property (@(posedge clock)
    disable iff (sys_rst)
    isa_mode && strobe_fall |=> latched_addr == $past(hp.addr))
    else $error("address not captured on strobe fall");

  a_wait_ready: assert property (@(posedge clock)
    disable iff (sys_rst)
    st_reg.state == HBPM_WAIT && isa_mode |-> !chan_ready)
    else $error("channel ready high during wait");

  a_cs_decode: assert property (@(posedge clock)
    disable iff (sys_rst)
    isa_mode && $stable(bus_mode) && $stable(base_addr) |=>
    io_cs16_n ==
      (latched_addr[HBPM_ADDR_W-1:HBPM_BASE_LSB] != base_addr))
    else $error("chip select decode wrong");

  a_ack_done: assert property (@(posedge clock)
    disable iff (sys_rst)
    !xfer_ack_n |-> !isa_mode && st_reg.state == HBPM_DONE)
    else $error("ack outside done state");

  a_ack_release: assert property (@(posedge clock)
    disable iff (sys_rst)
    st_reg.state == HBPM_DONE && cycle_end |=> xfer_ack_n)
    else $error("ack not released at cycle end");

  a_irq_route: assert property (@(posedge clock)
    disable iff (sys_rst)
    !isa_mode |-> !isa_interrupt_line_zero)
    else $error("isa line active in processor mode");

  a_rst_polar: assert property (@(posedge clock)
    disable iff (sys_rst)
    chip_rst == (isa_mode ? rst_pin_s : !rst_pin_s))
    else $error("chip reset polarity wrong");

  a_wait_len: assert property (@(posedge clock)
    disable iff (sys_rst)
    $rose(st_reg.state == HBPM_WAIT) && isa_mode |-> !chan_ready [*4])
    else $error("wait shorter than minimum");
endmodule
`default_nettype wire

// ### bench/hbpm_host_model.sv
// Host bus master model: strobes, address and byte enable.
// Assumes go inputs are pulsed for one cycle by non-blocking writes.
`timescale 1ns/1ps
`default_nettype none
module hbpm_host_model (
  input wire logic clock,
  input wire logic isa_go,
  input wire logic mpu_go,
  input wire logic [15:0] go_addr,
  input wire logic go_bhe_n,
  input wire logic xfer_ack_n,
  output hbpm_pkg::hbpm_host_s host_pins
);
  import hbpm_pkg::*;
  int n;
  // ==========================================================
  // Idle bus with strobes high, then the cycle engine in one process,
  // changing pins on falling edges only
  initial begin
    host_pins = '{1'b1, 1'b1, 1'b1, 16'h0000};
    forever begin
      @(negedge clock);
      if (isa_go) begin
        host_pins.addr = go_addr;
        host_pins.byte_high_n = go_bhe_n;
        repeat (3) @(negedge clock);
        host_pins.addr_strobe = 1'b0;
        repeat (6) @(negedge clock);
        host_pins.addr_strobe = 1'b1;
        host_pins.addr = ~go_addr; // Released bus shows no stale value
        host_pins.byte_high_n = ~go_bhe_n;
      end else if (mpu_go) begin
        host_pins.addr = go_addr;
        host_pins.data_strobe_n = 1'b0;
        for (n = 0; n < 40 && xfer_ack_n !== 1'b0; n++) @(negedge clock);
        @(negedge clock);
        host_pins.data_strobe_n = 1'b1;
        host_pins.addr = ~go_addr;
      end
    end
  end
endmodule
`default_nettype wire

// ### bench/tb_hbpm_core.sv
// Self-checking bench for the host bus pin mapping core.
// Assumes hbpm_pkg and the host model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_hbpm_core;
  import hbpm_pkg::*;
  logic clock = 1'b0, sys_rst = 1'b1, chip_reset_pin = 1'b0;
  logic irq_event = 1'b0, access_ready = 1'b0, isa_go = 1'b0;
  logic mpu_go = 1'b0, go_bhe_n = 1'b1;
  hbpm_mode_e bus_mode = HBPM_MODE_ISA;
  logic [15:0] go_addr = 16'h0000;
  logic [11:0] base_addr = 12'h3A5;
  hbpm_host_s host_pins;
  logic chan_ready, io_cs16_n, isa_interrupt_line_zero, mpu_irq;
  logic xfer_ack_n, latched_byte_high_n, access_req, chip_rst;
  logic [15:0] latched_addr;
  int fails = 0, comparisons = 0, n;
  // ==========================================================
  // Clock, design and host model
  always #2.5 clock = ~clock;
  hbpm_core #(.WAIT_CYC(4)) hbpm_core_i (.clock(clock),
    .sys_rst(sys_rst), .bus_mode(bus_mode),
    .chip_reset_pin(chip_reset_pin), .host_pins(host_pins),
    .base_addr(base_addr), .irq_event(irq_event),
    .access_ready(access_ready), .chan_ready(chan_ready),
    .io_cs16_n(io_cs16_n),
    .isa_interrupt_line_zero(isa_interrupt_line_zero),
    .mpu_irq(mpu_irq), .xfer_ack_n(xfer_ack_n),
    .latched_addr(latched_addr),
    .latched_byte_high_n(latched_byte_high_n),
    .access_req(access_req), .chip_rst(chip_rst));
  hbpm_host_model hbpm_host_model_i (.clock(clock), .isa_go(isa_go),
    .mpu_go(mpu_go), .go_addr(go_addr), .go_bhe_n(go_bhe_n),
    .xfer_ack_n(xfer_ack_n), .host_pins(host_pins));
  // ==========================================================
  // Compare, wait, reset and closing tasks
  task chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: word %h not %h", $time, got, exp);
    end
  endtask
  task chk1(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: flag %b not %b", $time, got, exp);
    end
  endtask
  task test_done;
    if (fails == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task wait_req;
    for (n = 0; n < 40 && access_req !== 1'b1; n++) @(negedge clock);
    if (n == 40) begin
      fails++;
      test_done;
    end
  endtask
  task start(input hbpm_mode_e m);
    bus_mode = m;
    sys_rst = 1'b1;
    repeat (20) @(negedge clock);
    sys_rst = 1'b0;
    repeat (3) @(negedge clock);
  endtask
  // ==========================================================
  // Scenarios
  task isa_access(input logic [15:0] a, input logic bhe, input logic hit);
    go_addr = a;
    go_bhe_n = bhe;
    access_ready = 1'b0;
    isa_go <= 1'b1;
    @(negedge clock);
    isa_go <= 1'b0;
    wait_req;
    chk(latched_addr, a);
    chk1(latched_byte_high_n, bhe);
    chk1(chan_ready, 1'b0);
    repeat (6) @(negedge clock);
    chk1(chan_ready, 1'b0);
    chk1(io_cs16_n, ~hit);
    access_ready = 1'b1;
    for (n = 0; n < 20 && chan_ready !== 1'b1; n++) @(negedge clock);
    chk1(chan_ready, 1'b1);
  endtask
  task mpu_access(input logic [15:0] a);
    go_addr = a;
    access_ready = 1'b0;
    mpu_go <= 1'b1;
    @(negedge clock);
    mpu_go <= 1'b0;
    wait_req;
    repeat (6) @(negedge clock);
    chk1(xfer_ack_n, 1'b1);
    access_ready = 1'b1;
    for (n = 0; n < 20 && xfer_ack_n !== 1'b0; n++) @(negedge clock);
    chk1(xfer_ack_n, 1'b0);
    for (n = 0; n < 20 && xfer_ack_n !== 1'b1; n++) @(negedge clock);
    chk1(xfer_ack_n, 1'b1);
  endtask
  task side_pins(input hbpm_mode_e m);
    irq_event = 1'b1;
    repeat (4) @(negedge clock);
    if (m == HBPM_MODE_MPU) chk1(mpu_irq, 1'b1);
    else chk1(isa_interrupt_line_zero, 1'b1);
    irq_event = 1'b0;
    chip_reset_pin = 1'b1;
    repeat (4) @(negedge clock);
    chk1(chip_rst, m == HBPM_MODE_ISA);
    chip_reset_pin = 1'b0;
    repeat (4) @(negedge clock);
    chk1(chip_rst, m == HBPM_MODE_MPU);
  endtask
  // Main sequence with a watchdog
  initial begin
    fork
      begin
        repeat (20000) @(negedge clock);
        fails++;
        test_done;
      end
    join_none
    start(HBPM_MODE_ISA);
    isa_access(16'h3A50, 1'b0, 1'b1);
    isa_access(16'h3A4F, 1'b1, 1'b0);
    isa_access(16'h3A5F, 1'b1, 1'b1);
    side_pins(HBPM_MODE_ISA);
    start(HBPM_MODE_MPU);
    mpu_access(16'h3A50);
    mpu_access(16'h0010);
    side_pins(HBPM_MODE_MPU);
    test_done;
  end
endmodule
`default_nettype wire
